// file: rtl/stbcg_top.v
// deep standby sequencer with per-clock dynamic gating
`include "stbcg_regs.vh"

module stbcg_top #(
   parameter NCLK       = 4,
   parameter NGPIO      = 8,
   parameter NDDR       = 4,
   parameter NCM        = 2,
   parameter ENTRY_CYC  = `STBCG_ENTRY_CYCLES,
   parameter HAS_DEGLITCH = 1
) (
   // clock and reset
   input  wire              ref_clk,
   input  wire              srst,
   // standby pin, active low
   input  wire              deep_standby_n,
   // pad clocks and their dynamic enables
   input  wire [NCLK-1:0]   pad_clk,
   input  wire [NCLK-1:0]   clk_en_async,
   output wire [NCLK-1:0]   core_clk,
   // general purpose io, core side and pad side
   input  wire [NGPIO-1:0]  gpio_core_out,
   input  wire [NGPIO-1:0]  gpio_core_oe,
   output reg  [NGPIO-1:0]  gpio_pad_out,
   output reg  [NGPIO-1:0]  gpio_pad_oe,
   input  wire [NGPIO-1:0]  gpio_pad_in,
   output reg  [NGPIO-1:0]  gpio_core_in,
   // double rate io
   input  wire [NDDR-1:0]   double_rate_io_core_out,
   input  wire [NDDR-1:0]   double_rate_io_core_oe,
   output reg  [NDDR-1:0]   double_rate_io_out,
   output reg  [NDDR-1:0]   double_rate_io_oe,
   output reg  [NDDR-1:0]   double_rate_io_pulldown,
   // clock managers and core retention
   output reg  [NCM-1:0]    clock_manager_rst,
   output reg               retain_hold,
   output reg               standby_reached
);
   localparam ST_RUN     = `STBCG_ST_RUN;
   localparam ST_ENTER   = `STBCG_ST_ENTER;
   localparam ST_STANDBY = `STBCG_ST_STANDBY;
   localparam ST_EXIT    = `STBCG_ST_EXIT;
   localparam CW         = 24;

   // ***********************************************************************
   // synchronisers
   // ***********************************************************************
   wire            stby_n_s;
   wire [NCLK-1:0] en_s;

   stbcg_sync #(.W(1)) u_sync_stby (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .rst_val  (1'b1),
      .async_in (deep_standby_n),
      .sync_out (stby_n_s)
   );

   stbcg_sync #(.W(NCLK)) u_sync_en (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .rst_val  ({NCLK{1'b0}}),
      .async_in (clk_en_async),
      .sync_out (en_s)
   );

   // ***********************************************************************
   // standby state machine
   // ***********************************************************************
   reg [1:0]    state;
   reg [1:0]    next_state;
   reg [CW-1:0] cnt;
   reg [CW-1:0] next_cnt;
   reg          gate_all;

   always @* begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         ST_RUN: begin
            next_cnt = {CW{1'b0}};
            if (!stby_n_s) begin
               next_state = ST_ENTER;
            end
         end
         ST_ENTER: begin
            if (stby_n_s) begin
               next_state = ST_EXIT;
            end else if (cnt == ENTRY_CYC[CW-1:0] - 1'b1) begin
               next_state = ST_STANDBY;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         ST_STANDBY: begin
            if (stby_n_s) begin
               next_state = ST_EXIT;
            end
         end
         ST_EXIT: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         state <= ST_RUN;
         cnt   <= {CW{1'b0}};
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // ***********************************************************************
   // pin and retention control
   // ***********************************************************************
   wire in_stby = (state != ST_RUN) || !stby_n_s;

   always @(posedge ref_clk) begin
      if (srst) begin
         gpio_pad_out            <= {NGPIO{1'b0}};
         gpio_pad_oe             <= {NGPIO{1'b0}};
         gpio_core_in            <= {NGPIO{1'b1}};
         double_rate_io_out      <= {NDDR{1'b0}};
         double_rate_io_oe       <= {NDDR{1'b0}};
         double_rate_io_pulldown <= {NDDR{1'b0}};
         clock_manager_rst       <= {NCM{1'b1}};
         retain_hold             <= 1'b0;
         standby_reached         <= 1'b0;
         gate_all                <= 1'b0;
      end else begin
         gate_all        <= in_stby;
         retain_hold     <= in_stby;
         standby_reached <= (state == ST_STANDBY);
         clock_manager_rst <= {NCM{in_stby}};
         if (in_stby) begin
            // gpio pad outputs frozen at their last values, core inputs forced high, double rate pins released and pulled down
            gpio_core_in            <= {NGPIO{1'b1}};
            double_rate_io_out      <= {NDDR{1'b0}};
            double_rate_io_oe       <= {NDDR{1'b0}};
            double_rate_io_pulldown <= {NDDR{1'b1}};
         end else begin
            gpio_pad_out            <= gpio_core_out;
            gpio_pad_oe             <= gpio_core_oe;
            gpio_core_in            <= gpio_pad_in;
            double_rate_io_out      <= double_rate_io_core_out;
            double_rate_io_oe       <= double_rate_io_core_oe;
            double_rate_io_pulldown <= {NDDR{1'b0}};
         end
      end
   end

   // ***********************************************************************
   // clock gates
   // ***********************************************************************
   reg [NCLK-1:0] gate_en;

   always @(posedge ref_clk) begin
      if (srst) begin
         gate_en <= {NCLK{1'b0}};
      end else begin
         gate_en <= en_s & {NCLK{~gate_all}};
      end
   end

   genvar g;
   generate
      if (HAS_DEGLITCH != 0) begin : g_dgl
         for (g = 0; g < NCLK; g = g + 1) begin : g_gate
            stbcg_gate u_gate (
               .pad_clk   (pad_clk[g]),
               .enable    (gate_en[g]),
               .gated_clk (core_clk[g])
            );
         end
      end else begin : g_raw
         // smaller variant: plain gating, glitch prevention left to the system
         for (g = 0; g < NCLK; g = g + 1) begin : g_gate
            assign core_clk[g] = pad_clk[g] & gate_en[g];
         end
      end
   endgenerate
endmodule // stbcg_top

// file: rtl/stbcg_regs.vh
// timing constants and state encodings of the standby and clock gating block
// ***************************************************************************
// Summary of operation
// - the standby pin is active low, driven low to enter deep standby and high to run.
// - in standby every general purpose output keeps its previous drive state.
// - in standby every double rate pin is pulled low through a weak pull-down.
// - all flip-flops, memory and fifo state hold their values across standby.
// - in standby every input clock is gated off regardless of its own enable.
// - in standby every general purpose input path into logic reads a weak one.
// - in standby every clock manager is held in reset.
// - each input clock may be dynamically switched on and off at its pad.
// - asynchronous enable changes never produce a runt pulse or false edge.
// - the same glitch suppression applies on standby entry and exit.
// - entry into standby takes typically 250 us and at most 300 us.
// ***************************************************************************
`ifndef STBCG_REGS_VH
`define STBCG_REGS_VH
`define STBCG_REF_CLK_MHZ     50
`define STBCG_ENTRY_TYP_US    250
`define STBCG_ENTRY_MAX_US    300
`define STBCG_ENTRY_CYCLES    (`STBCG_ENTRY_TYP_US * `STBCG_REF_CLK_MHZ)
`define STBCG_ENTRY_MAX_CYC   (`STBCG_ENTRY_MAX_US * `STBCG_REF_CLK_MHZ)
`define STBCG_SYNC_STAGES     2
`define STBCG_ST_RUN          2'h0
`define STBCG_ST_ENTER        2'h1
`define STBCG_ST_STANDBY      2'h2
`define STBCG_ST_EXIT         2'h3
`endif

// file: rtl/stbcg_sync.v
// two stage synchroniser for a bus of levels
module stbcg_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         ref_clk,
   input  wire         srst,
   input  wire [W-1:0] rst_val,
   // levels
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] meta;

   always @(posedge ref_clk) begin
      // reset to the caller's idle level, so no false request follows reset
      if (srst) begin
         meta     <= rst_val;
         sync_out <= rst_val;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule // stbcg_sync

// file: rtl/stbcg_gate.v
// glitch-free pad clock gate, enable taken only while the clock is low
module stbcg_gate (
   // clock to gate
   input  wire pad_clk,
   // enable, already free of glitches in the ref_clk domain
   input  wire enable,
   // gated clock
   output wire gated_clk
);
   reg en_low;

   // transparent while low, so a high phase is never cut
   always @* begin
      if (!pad_clk) begin
         en_low = enable;
      end else begin
         en_low = en_low;
      end
   end

   assign gated_clk = pad_clk & en_low;
endmodule // stbcg_gate

// file: sim/stbcg_sva.sv
// assertions on the ports of the standby and clock gating top
module stbcg_sva #(
   parameter NCLK = 4, NGPIO = 8, NDDR = 4, NCM = 2, ENTRY_CYC = 20
) (
   input wire             ref_clk, srst, deep_standby_n, retain_hold, standby_reached,
   input wire [NCLK-1:0]  clk_en_async, core_clk,
   input wire [NGPIO-1:0] gpio_pad_out, gpio_pad_oe, gpio_core_in,
   input wire [NDDR-1:0]  double_rate_io_oe, double_rate_io_pulldown,
   input wire [NCM-1:0]   clock_manager_rst
);
   logic [15:0] low_cnt;
   // cycles the pin has been low without a break
   always @(posedge ref_clk) low_cnt <= (srst || deep_standby_n) ? 16'h0 : low_cnt + 16'h1;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   property p_cm; !deep_standby_n [*5] |-> &clock_manager_rst && retain_hold; endproperty
   a_cm: assert property (p_cm) else $error("managers or retention not held");
   property p_ones; !deep_standby_n [*5] |-> &gpio_core_in; endproperty
   a_ones: assert property (p_ones) else $error("core inputs not forced high");
   property p_ddr; !deep_standby_n [*5] |-> &double_rate_io_pulldown && !double_rate_io_oe;
   endproperty
   a_ddr: assert property (p_ddr) else $error("double rate pins not pulled low");
   property p_hold; !deep_standby_n [*5] |=> $stable(gpio_pad_out) && $stable(gpio_pad_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("pad outputs moved in standby");
   property p_gate; !deep_standby_n [*8] |-> core_clk == 0; endproperty
   a_gate: assert property (p_gate) else $error("clock runs in standby");
   property p_early; standby_reached && !deep_standby_n |-> low_cnt > ENTRY_CYC; endproperty
   a_early: assert property (p_early) else $error("standby reached too early");
   property p_late; low_cnt == ENTRY_CYC + 8 |-> standby_reached; endproperty
   a_late: assert property (p_late) else $error("standby not reached in time");
   property p_run; deep_standby_n [*6] |-> !retain_hold && !clock_manager_rst && !standby_reached;
   endproperty
   a_run: assert property (p_run) else $error("standby state outside standby");
   property p_en; !clk_en_async[0] [*8] |-> !core_clk[0]; endproperty
   a_en: assert property (p_en) else $error("disabled clock still toggles");
endmodule // stbcg_sva
bind stbcg_top stbcg_sva #(.NCLK(NCLK), .NGPIO(NGPIO), .NDDR(NDDR), .NCM(NCM),
   .ENTRY_CYC(ENTRY_CYC)) stbcg_sva_inst (.ref_clk, .srst, .deep_standby_n, .retain_hold,
   .standby_reached, .clk_en_async, .core_clk, .gpio_pad_out, .gpio_pad_oe, .gpio_core_in,
   .double_rate_io_oe, .double_rate_io_pulldown, .clock_manager_rst);

// file: sim/stbcg_sys.sv
// system logic model driving the standby pin, clock enables and pad clocks
module stbcg_sys (
   // requests from the bench
   input  logic       stby_req,
   input  logic [3:0] en_req,
   // pins toward the device
   output logic       deep_standby_n,
   output logic [3:0] clk_en_async,
   output logic [3:0] pad_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   // levels land off the ref_clk edge and unrelated to pad clocks
   assign #3 deep_standby_n = !stby_req;
   assign #5 clk_en_async = en_req;
   initial pad_clk = 4'h0;
   // free-running pads, none taken from a general input
   for (genvar i = 0; i < 4; i++) begin : g_pad
      always #(7 + 4 * i) pad_clk[i] = ~pad_clk[i];
   end
endmodule // stbcg_sys

// file: sim/stbcg_tb.sv
// self-checking bench for the standby and clock gating block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk = 0, srst = 1, stby_req = 0, deep_standby_n, retain_hold, standby_reached;
   logic [3:0] en_req = 4'hF, dc_out = 4'h9, dc_oe = 4'h6, pad_clk, clk_en_async, core_clk;
   logic [3:0] d_out, d_oe, d_pd;
   logic [7:0] g_out = 8'hA5, g_oe = 8'h3C, g_in = 8'h5A, g_pad_out, g_pad_oe, g_core_in;
   logic [1:0] cm_rst;
   int         err_count = 0, tests_run = 0, cyc = 0, edges = 0;
   realtime    t_rise = 0;
   stbcg_top #(.ENTRY_CYC(20)) stbcg_top_inst (.ref_clk, .srst, .deep_standby_n, .pad_clk,
      .clk_en_async, .core_clk, .gpio_core_out(g_out), .gpio_core_oe(g_oe), .gpio_pad_out(g_pad_out),
      .gpio_pad_oe(g_pad_oe), .gpio_pad_in(g_in), .gpio_core_in(g_core_in),
      .double_rate_io_core_out(dc_out), .double_rate_io_core_oe(dc_oe), .double_rate_io_out(d_out),
      .double_rate_io_oe(d_oe), .double_rate_io_pulldown(d_pd), .clock_manager_rst(cm_rst),
      .retain_hold, .standby_reached);
   stbcg_sys stbcg_sys_inst (.stby_req, .en_req, .deep_standby_n, .clk_en_async, .pad_clk);
   initial forever #10 ref_clk = ~ref_clk;
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task cyc_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   always @(posedge ref_clk) if (++cyc == 3000) begin
      err_count++;
      final_report;
   end
   // every gated high pulse on core_clk[0] keeps the full 7 ns pad half period
   always @(posedge core_clk[0]) begin
      edges++;
      t_rise = $realtime;
   end
   always @(negedge core_clk[0]) if (t_rise > 0) chk($realtime - t_rise == 7.0, 1);
   task t_run;
      cyc_n(4);
      chk({g_pad_out, g_pad_oe, g_core_in}, 24'hA53C5A);
      chk({d_out, d_oe, d_pd, cm_rst}, {4'h9, 4'h6, 4'h0, 2'h0});
   endtask
   task t_gate;
      en_req = 4'hE;
      cyc_n(8);
      edges = 0;
      cyc_n(10);
      chk(edges, 0);
      en_req = 4'hF;
      cyc_n(8);
      edges = 0;
      cyc_n(5);
      chk(edges > 4, 1);
   endtask
   task t_standby(input int hold);
      stby_req = 1;
      cyc_n(6);
      g_out = 8'h0F;
      g_oe = 8'hF0;
      g_in = 8'h00;
      cyc_n(3);
      chk({g_pad_out, g_pad_oe, g_core_in}, 24'hA53CFF);
      chk({d_out, d_oe, d_pd, cm_rst, retain_hold}, {4'h0, 4'h0, 4'hF, 2'h3, 1'b1});
      edges = 0;
      cyc_n(hold);
      chk(edges, 0);
      chk(standby_reached, hold > 20);
      stby_req = 0;
      cyc_n(6);
      chk({g_pad_out, g_pad_oe, g_core_in, cm_rst, retain_hold}, {24'h0FF000, 2'h0, 1'b0});
      g_out = 8'hA5;
      g_oe = 8'h3C;
      g_in = 8'h5A;
   endtask
   initial begin
      cyc_n(12);
      srst = 0;
      cyc_n(8);
      t_run;
      t_gate;
      t_standby(10);
      t_standby(40);
      t_run;
      final_report;
   end
endmodule // tb
